/* File: sac_pkg.sv */
package sac_pkg;

  // Result layout
  localparam int RESULT_W      = 10;
  localparam int UPPER_W       = 8;
  localparam int LOWER_W       = 2;
  localparam logic [9:0] RESULT_RST = 10'h000;
  localparam logic [9:0] OFFSET_CODE = 10'h200;

  // Timing
  localparam int CLK_PERIOD_NS   = 25;
  localparam int RESET_MAX_NS    = 1500;
  localparam int BIT_PERIOD_NS   = 2000;
  // Reset phase lasts half the longest time, rounded down
  localparam int RESET_CYCLES    = RESET_MAX_NS / CLK_PERIOD_NS / 2;
  localparam int BIT_CYCLES      = BIT_PERIOD_NS / CLK_PERIOD_NS;
  localparam int TIMER_W         = 8;

  typedef enum logic [1:0] {
    SAC_IDLE,
    SAC_RESET,
    SAC_WAIT_FALL,
    SAC_CONVERT
  } sac_state_t;

endpackage

/* File: sac_sar_ctrl.sv */
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// RULE1: host holds trigger high at least 500 ns
// RULE2: trigger rise resets, ready high within 1.5us
// RULE3: conversion starts on trigger falling edge; a fall inside the reset phase starts it at the end of that phase
// RULE4: decide bits from MSB down to LSB
// RULE5: set trial bit, clear if comparator high
// RULE6: ready low once all ten bits decided
// RULE7: enables drive upper eight, lower two bits
// RULE8: host raises enables before next trigger
// RULE9: bipolar mode adds MSB minus half LSB
// RULE10: bipolar zero input gives mid-scale code
// RULE11: host reads one word or two parts
// RULE12: one decision per internal clock period
// RULE13: new trigger rise aborts and restarts
module sac_sar_ctrl #(
  parameter int BIT_CYCLES_P   = sac_pkg::BIT_CYCLES,
  parameter int RESET_CYCLES_P = sac_pkg::RESET_CYCLES
) (
  input  wire logic                        core_clk_in,
  input  wire logic                        sys_rst_in,
  input  wire logic                        convert_trigger_in,
  input  wire logic                        comparator_high_in,
  input  wire logic                        bipolar_select_in,
  input  wire logic                        upper_byte_output_enable_n_in,
  input  wire logic                        lower_pair_output_enable_n_in,
  output logic [sac_pkg::RESULT_W-1:0]     dac_code_out,
  output logic                             bipolar_offset_on_out,
  output logic                             result_ready_n_out,
  output logic [sac_pkg::UPPER_W-1:0]      upper_data_out,
  output logic [sac_pkg::UPPER_W-1:0]      upper_data_oe_out,
  output logic [sac_pkg::LOWER_W-1:0]      lower_data_out,
  output logic [sac_pkg::LOWER_W-1:0]      lower_data_oe_out
);
  import sac_pkg::*;

  sac_state_t              state;
  logic                    trig_q;
  logic [TIMER_W-1:0]      timer;
  logic [RESULT_W-1:0]     sar;
  logic [RESULT_W-1:0]     trial;
  logic                    ready_n;

  logic trig_rise;
  logic trig_fall;
  logic timer_done;
  logic reset_end;
  logic start_conv;
  logic decide;
  logic last_decide;

  //////////////////////////////////////////////////////////////////////////////
  // Decoding helpers

  // Trial word holding only the top bit
  function automatic logic [RESULT_W-1:0] msb_trial();
    msb_trial = {1'b1, {(RESULT_W-1){1'b0}}};
  endfunction

  // Keep or drop the trial bit on the comparator verdict
  // A high verdict means the trial sum overshoots the input
  function automatic logic [RESULT_W-1:0] judge_bit(
    input logic [RESULT_W-1:0] cur,
    input logic [RESULT_W-1:0] bit_mask,
    input logic                too_big
  );
    if (too_big) begin
      judge_bit = cur & ~bit_mask;
    end else begin
      judge_bit = cur | bit_mask;
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Trigger edge detection
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      trig_q <= 1'b0;
    end else begin
      trig_q <= convert_trigger_in;
    end
  end

  assign trig_rise  = convert_trigger_in & ~trig_q;
  assign trig_fall  = ~convert_trigger_in & trig_q;
  assign timer_done = (timer == '0);

  //////////////////////////////////////////////////////////////////////////////
  // Phase decoding shared by the processes below
  // A fall inside the reset phase must not be lost: a host pulse may be
  // shorter than the phase, so a low trigger level at the end of the
  // phase starts the conversion there and then.
  assign reset_end   = (state == SAC_RESET) && timer_done;
  assign start_conv  = !trig_rise
                       && ((state == SAC_WAIT_FALL && trig_fall)
                       || (reset_end && !convert_trigger_in));
  assign decide      = (state == SAC_CONVERT) && timer_done;
  assign last_decide = decide && trial[0];

  //////////////////////////////////////////////////////////////////////////////
  // Sequencer state; a trigger rise always wins
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      state <= SAC_IDLE;
    end else if (trig_rise) begin
      state <= SAC_RESET;                              // [RULE2] [RULE13]
    end else if (start_conv) begin
      state <= SAC_CONVERT;                            // [RULE3]
    end else begin
      unique case (state)
        SAC_IDLE: begin
          state <= SAC_IDLE;
        end
        SAC_RESET: begin
          if (timer_done) begin
            state <= SAC_WAIT_FALL;
          end
        end
        SAC_WAIT_FALL: begin
          state <= SAC_WAIT_FALL;
        end
        SAC_CONVERT: begin
          if (last_decide) begin
            state <= SAC_IDLE;
          end
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Phase timer: reset phase length, then one period per bit
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      timer <= '0;
    end else if (trig_rise) begin
      timer <= TIMER_W'(RESET_CYCLES_P - 1);           // [RULE2]
    end else if (start_conv || decide) begin
      timer <= TIMER_W'(BIT_CYCLES_P - 1);             // [RULE12]
    end else if (!timer_done && (state == SAC_RESET
                                 || state == SAC_CONVERT)) begin
      timer <= timer - 1'b1;                           // [RULE12]
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Trial bit walks from the top down, cleared on abort
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      trial <= '0;
    end else if (trig_rise) begin
      trial <= '0;                                     // [RULE13]
    end else if (start_conv) begin
      trial <= msb_trial();                            // [RULE4]
    end else if (decide) begin
      trial <= trial >> 1;                             // [RULE4]
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Approximation register
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      sar <= RESULT_RST;
    end else if (trig_rise) begin
      sar <= RESULT_RST;                               // [RULE13]
    end else if (decide) begin
      // Verdict taken at the end of the bit period, trial sum settled
      sar <= judge_bit(sar, trial, comparator_high_in); // [RULE5]
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Ready flag: high from reset phase until last decision
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      ready_n <= 1'b1;
    end else if (trig_rise) begin
      ready_n <= 1'b1;                                 // [RULE2]
    end else if (last_decide) begin
      ready_n <= 1'b0;                                 // [RULE6]
    end
  end

  // Trial sum seen by the comparator, offset switch
  assign dac_code_out          = sar | trial;          // [RULE5]
  assign bipolar_offset_on_out = bipolar_select_in;    // [RULE9] [RULE10]
  assign result_ready_n_out    = ready_n;

  //////////////////////////////////////////////////////////////////////////////
  // Output buffers, each enable on its own
  // Data lags the register by one cycle; the lower pair still shows the old LSB in the first cycle of ready low
  // Upper byte register
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      upper_data_out <= '0;
    end else begin
      upper_data_out <= sar[RESULT_W-1 -: UPPER_W];    // [RULE7]
    end
  end

  // Lower pair register
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      lower_data_out <= '0;
    end else begin
      lower_data_out <= sar[LOWER_W-1:0];              // [RULE7]
    end
  end

  // Enables drive every bit of their group

  assign upper_data_oe_out = {UPPER_W{~upper_byte_output_enable_n_in}};
  assign lower_data_oe_out = {LOWER_W{~lower_pair_output_enable_n_in}};

endmodule // sac_sar_ctrl

/* File: sac_cmp_model.sv */
`timescale 1ns/1ps
// Comparator: high while the trial code exceeds the input
module sac_cmp_model (
  input  wire logic [9:0] dac_code_in,
  input  wire logic [9:0] vin_in,
  output logic            high_out
);
  assign high_out = dac_code_in > vin_in;
endmodule // sac_cmp_model

/* File: sac_chk.sv */
`timescale 1ns/1ps
module sac_chk (
  input wire logic       core_clk_in,
  input wire logic       sys_rst_in,
  input wire logic       convert_trigger_in,
  input wire logic       bipolar_select_in,
  input wire logic       upper_byte_output_enable_n_in,
  input wire logic [9:0] dac_code_out,
  input wire logic       bipolar_offset_on_out,
  input wire logic       result_ready_n_out,
  input wire logic [7:0] upper_data_oe_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (sys_rst_in);
  // Trigger edges
  sequence s_rise; $rose(convert_trigger_in); endsequence
  sequence s_fall; $fell(convert_trigger_in); endsequence
  property p_rdy; s_rise |-> ##[1:60] result_ready_n_out; endproperty
  a_rdy: assert property (p_rdy) else $error("late");
  property p_hold; convert_trigger_in [*2] |-> result_ready_n_out; endproperty
  a_hold: assert property (p_hold) else $error("early");
  property p_msb; s_fall |-> ##[1:2] dac_code_out == 10'h200; endproperty
  a_msb: assert property (p_msb) else $error("msb");
  property p_busy; s_fall |-> result_ready_n_out [*8]; endproperty
  a_busy: assert property (p_busy) else $error("busy");
  property p_keep;
    !result_ready_n_out && !convert_trigger_in |=> !result_ready_n_out;
  endproperty
  a_keep: assert property (p_keep) else $error("keep");
  property p_clr; s_rise |=> dac_code_out == 10'h000; endproperty
  a_clr: assert property (p_clr) else $error("abort");
  property p_uoe;
    upper_data_oe_out == {8{!upper_byte_output_enable_n_in}};
  endproperty
  a_uoe: assert property (p_uoe) else $error("oe");
  property p_off; bipolar_offset_on_out == bipolar_select_in; endproperty
  a_off: assert property (p_off) else $error("off");
endmodule // sac_chk
bind sac_sar_ctrl sac_chk i_chk (.*);

/* File: sac_sar_ctrl_tb.sv */
`timescale 1ns/1ps
module sac_sar_ctrl_tb;
  logic clk = 0, rst = 1, trig = 0, bip = 0, hen = 1, len = 1;
  logic cmp, rdy_n, off;
  logic [9:0] vin = 0, dac, e;
  logic [7:0] ud, uoe;
  logic [1:0] ld, loe;
  int fails = 0, compares = 0, n;
  integer seed = 32'hba2f_c14e;
  always #12.5 clk = ~clk;
  sac_sar_ctrl #(.BIT_CYCLES_P(3), .RESET_CYCLES_P(2)) i_dut (
    .core_clk_in(clk), .sys_rst_in(rst), .convert_trigger_in(trig),
    .comparator_high_in(cmp), .bipolar_select_in(bip),
    .upper_byte_output_enable_n_in(hen),
    .lower_pair_output_enable_n_in(len), .dac_code_out(dac),
    .bipolar_offset_on_out(off), .result_ready_n_out(rdy_n),
    .upper_data_out(ud), .upper_data_oe_out(uoe),
    .lower_data_out(ld), .lower_data_oe_out(loe));
  sac_cmp_model i_cmp (.dac_code_in(dac), .vin_in(vin), .high_out(cmp));
  // Step k cycles, landing just after the edge
  task t(int k);
    repeat (k) begin @(posedge clk); #2; end
  endtask
  task c(logic [19:0] g, logic [19:0] w);
    compares++;
    if (g !== w) begin
      fails++;
      $display("unexpected %0t %h %h", $time, g, w);
    end
  endtask
  task summarize;
    $display("fails %0d compares %0d", fails, compares);
    if (fails == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Trial each bit from the top, keeping it unless it overshoots
  function logic [9:0] sar(logic [9:0] v);
    sar = 0;
    for (int i = 9; i >= 0; i--) if ((sar | 10'h1 << i) <= v) sar |= 10'h1 << i;
  endfunction
  // One conversion; ab extra passes are cut short by a new trigger
  task cv(logic [9:0] v, logic b, int ab);
    vin = v;
    bip = b;
    e = sar(v);
    for (int k = ab; k >= 0; k--) begin
      trig = 1;
      t(20);
      trig = 0;
      t(k * 12);
    end
    for (n = 0; n < 99 && rdy_n; n++) t(1);
    c(rdy_n, 0);
    if (rdy_n !== 1'b0) summarize;
    c(n >= 29 && n <= 33, 1);
    hen = 0;
    len = !b;
    t(2);
    c({uoe, loe, ud, ld}, {8'hff, {2{b}}, e});
    hen = 1;
    len = 0;
    t(2);
    c({uoe, loe, ld}, {10'h003, e[1:0]});
    len = 1;
    c(off, b);
  endtask
  initial begin
    t(3);
    rst = 0;
    cv(10'h000, 0, 0);
    cv(10'h200, 1, 0);
    cv(10'h3ff, 0, 1);
    repeat (8) cv(10'($random(seed)), 1'($random(seed)), 0);
    summarize;
  end
endmodule // sac_sar_ctrl_tb
